// ---- hdl/ims_master_seq.sv ----
// Two-wire bus master sequencer: Start, Repeated Start, byte transmit and receive.
// Assumes synchronised sampling of pins is done here; pins are open drain outside.
`default_nettype none
module ims_master_seq
	import ims_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe_n,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe_n
);
	// States of the sequencer. Every state except idle, S_RS_LOW, S_RS_SCLUP and the
	// last S_RX_LOW of a byte spends at least one counter period before it moves on, unless a
	// collision aborts it; the counter loads on every change to a state other than idle, so the timed phases of a condition but S_RS_SDA last one full period.
	// The Start path uses two states: the first waits with both lines
	// released, the second holds data low with the clock still released.
	// The Repeated Start path first pulls the clock low, then releases data,
	// then releases the clock and waits for it to read high, then checks that
	// both lines stay high for a period before it pulls data low for one more.
	// Transmit and receive alternate a low and a high state per bit, and the
	// bit counter advances once per clock pulse.
	// Idle is also the resting state after a byte. The clock stays pulled low
	// there until the next command, which is how the bus is held between bytes.
	typedef enum logic [3:0] {
		S_IDLE, S_ST_WAIT, S_ST_HOLD,
		S_RS_LOW, S_RS_SDA, S_RS_SCLUP, S_RS_HIGH, S_RS_HOLD,
		S_TX_LOW, S_TX_HIGH, S_RX_LOW, S_RX_HIGH
	} ims_state_e;

	ims_state_e state_q, state_d;
	logic [1:0] sdaSync_q, sclSync_q;
	logic [6:0] reload_q;
	logic [6:0] brg_q;
	logic [7:0] buf_q, shift_q;
	logic [3:0] bitCnt_q;
	logic       startReq_q, restartReq_q, recvReq_q;
	logic       ack_status_q, write_collision_q, coll_q, irq_q;
	logic       bufFull_q, startSeen_q, ovf_q;
	logic       sdaLow_q, sclLow_q;
	logic [1:0] wcolWin_q;
	logic       ack_q;
	logic [31:0] rdData_q;

	// Synchronised pin levels; only the second stage is read by logic.
	// The two stages add a delay of two clocks to every line reading. This is
	// short against a counter period, so the sequencer still sees a stretched
	// clock before it would count the high time.
	wire        sdaHi     = sdaSync_q[1];
	wire        sclHi     = sclSync_q[1];
	wire        brgZero   = (brg_q <= 7'h01);
	wire        hit       = (avs_read | avs_write) & ~ack_q;
	wire        wrHit     = avs_write & ~ack_q;
	wire        rdHit     = avs_read & ~ack_q;
	// Register decode. A request is taken once, in the cycle before the
	// answer, so a held request cannot act twice on a request bit or a flag.
	// Byte lane one of the second control register enables the flag clears; the write
	// collision clear is bit 7 in lane zero, and software can clear flags without touching the request bits.
	wire        wrCtrl    = wrHit & (avs_address == OFS_CTRL2) & avs_byteenable[0];
	wire        wrFlags   = wrHit & (avs_address == OFS_CTRL2) & avs_byteenable[1];
	wire        wrStatus  = wrHit & (avs_address == OFS_STATUS) & avs_byteenable[0];
	wire        wrReload  = wrHit & (avs_address == OFS_RELOAD) & avs_byteenable[0];
	wire        wrBuf     = wrHit & (avs_address == OFS_BUF) & avs_byteenable[0];
	wire        rdBuf     = rdHit & (avs_address == OFS_BUF);
	wire        idle      = (state_q == S_IDLE);
	wire        inStartRs = startReq_q | restartReq_q;
	wire        shifting  = (state_q == S_TX_LOW) | (state_q == S_TX_HIGH);
	wire        inRx      = recvReq_q;
	wire        bufBlock  = inStartRs | inRx;                          // [RULE6]
	wire        bufTx     = wrBuf & idle & ~bufBlock;                  // [RULE12]
	wire        bufLate   = wrBuf & shifting & (wcolWin_q != 2'h0);    // [RULE17]
	wire        ctrlOk    = wrCtrl & idle & ~inStartRs;                // [RULE7]
	wire        goStart   = ctrlOk & avs_writedata[C2_START];
	wire        goRestart = ctrlOk & ~goStart & avs_writedata[C2_RESTART]; // [RULE8]
	wire        goRecv    = ctrlOk & ~goStart & ~goRestart & avs_writedata[C2_RECV]; // [RULE18]
	wire        rxDone    = (state_q == S_RX_LOW) & (bitCnt_q == BITS_BYTE);
	wire        txAck     = (state_q == S_TX_HIGH) & brgZero & (bitCnt_q == BITS_ACK);
	wire        rsColl    = ((state_q == S_RS_HIGH) & (~sdaHi | ~sclHi))
	                      | ((state_q == S_RS_SCLUP) & sclHi & ~sdaHi);        // [RULE11]
	wire        stColl    = (state_q == S_ST_WAIT) & (~sclHi | ~sdaHi);       // [RULE5]
	wire        startColl = goStart & ~sdaHi & ~sclHi;                        // [RULE5]

	always_ff @(posedge clk_sys) begin
		sdaSync_q <= {sdaSync_q[0], sdaIn};
		sclSync_q <= {sclSync_q[0], sclIn};
	end

	// Sequencer state.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (goStart && !startColl)
					state_d = S_ST_WAIT;                                 // [RULE2]
				else if (goRestart)
					state_d = S_RS_LOW;                                  // [RULE9]
				else if (goRecv)
					state_d = S_RX_LOW;
				else if (bufTx)
					state_d = S_TX_LOW;                                  // [RULE12]
			end
			S_ST_WAIT: begin
				if (stColl)
					state_d = S_IDLE;                                    // [RULE5]
				else if (brgZero)
					state_d = S_ST_HOLD;                                 // [RULE3]
			end
			S_ST_HOLD:  if (brgZero) state_d = S_IDLE;                   // [RULE4]
			S_RS_LOW:   if (!sclHi) state_d = S_RS_SDA;
			S_RS_SDA:   if (brgZero && sdaHi) state_d = S_RS_SCLUP;
			S_RS_SCLUP: begin
				if (rsColl)
					state_d = S_IDLE;
				else if (sclHi)
					state_d = S_RS_HIGH;
			end
			S_RS_HIGH: begin
				if (rsColl)
					state_d = S_IDLE;                                    // [RULE11]
				else if (brgZero)
					state_d = S_RS_HOLD;
			end
			S_RS_HOLD:  if (brgZero) state_d = S_IDLE;                   // [RULE10]
			S_TX_LOW:   if (brgZero) state_d = S_TX_HIGH;                // [RULE13]
			S_TX_HIGH: begin
				if (txAck)
					state_d = S_IDLE;                                    // [RULE16]
				else if (brgZero)
					state_d = S_TX_LOW;
			end
			S_RX_LOW: begin
				if (rxDone)
					state_d = S_IDLE;                                    // [RULE19]
				else if (brgZero)
					state_d = S_RX_HIGH;
			end
			S_RX_HIGH:  if (brgZero) state_d = S_RX_LOW;
			default:    state_d = S_IDLE;
		endcase
	end

	// Counter steps by two per clock; in S_TX_HIGH, S_RX_HIGH and S_RS_SCLUP a released SCL holds it until the line reads high.
	// Holding it at the reload value while the line is still low means that
	// the high time is counted only from the moment the line is seen high.
	// A slave that stretches the clock therefore never shortens the high time.
	// The Repeated Start data phase loads only the low six reload bits, so
	// that phase is shorter than the others whenever reload bit 6 is set.
	wire sclWait = ((state_q == S_TX_HIGH) | (state_q == S_RX_HIGH)
	              | (state_q == S_RS_SCLUP)) & ~sclHi;                     // [RULE1]
	wire brgLoad = (state_d != state_q) | (brgZero & ~idle);
	wire [6:0] brgLoadVal = (state_d == S_RS_SDA) ? {1'b0, reload_q[5:0]} : reload_q; // [RULE9]
	always_ff @(posedge clk_sys) begin
		if (rst)
			brg_q <= 7'h00;
		else if (sclWait)
			brg_q <= reload_q;                                           // [RULE1]
		else if (brgLoad && state_d != S_IDLE)
			brg_q <= brgLoadVal;                                         // [RULE22]
		else if (!brgZero)
			brg_q <= brg_q - 7'h02;                                      // [RULE22]
		else
			brg_q <= 7'h00;
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			state_q <= S_IDLE;
		else
			state_q <= state_d;
	end

	// Open-drain drive; a low drive bit releases the line.
	// The data bit for a new clock low phase is taken from what the shifter
	// will hold after this edge: the written byte when a transfer begins, the
	// next lower bit when a high phase ends. Reading the shifter itself here
	// would put out the previous bit, one bit late.
	// Within a transmitted byte, data changes only on the edge that pulls the clock low,
	// so it is never seen to move while the clock is released.
	wire txNextBit = (state_q == S_IDLE) ? avs_writedata[7] : shift_q[6];  // [RULE13]
	wire sdaLow_d = (state_d == S_ST_HOLD) | (state_d == S_RS_HOLD)
	              | ((state_q == S_ST_HOLD) & (state_d == S_IDLE)) ? 1'b1 :
	                ((state_d == S_TX_LOW) & (bitCnt_q == BITS_BYTE))
	                  | (state_d == S_RX_LOW) | (state_d == S_RX_HIGH)
	                  | (state_d == S_RS_SDA) | (state_d == S_RS_SCLUP)
	                  | (state_d == S_RS_HIGH) | (stColl | rsColl) ? 1'b0 :
	                (state_d == S_TX_LOW) & (state_q != S_TX_LOW) ? ~txNextBit : sdaLow_q;
	// The clock is pulled low for every low phase and kept low in idle after
	// a Start or a byte; a collision during a condition lets both lines go, one at the Start request leaves them as they were.
	wire sclLow_d = (state_d == S_RS_LOW) | (state_d == S_RS_SDA)
	              | (state_d == S_TX_LOW) | (state_d == S_RX_LOW)
	              | ((state_q == S_ST_HOLD) & (state_d == S_IDLE))
	              | (txAck | rxDone) | (idle & sclLow_q & ~(stColl | rsColl));
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sdaLow_q <= 1'b0;
			sclLow_q <= 1'b0;
		end else begin
			sdaLow_q <= sdaLow_d;                                        // [RULE13]
			sclLow_q <= sclLow_d;                                        // [RULE23]
		end
	end
	assign sdaOut  = 1'b0;
	assign sclOut  = 1'b0;
	assign sdaOe_n = ~sdaLow_q;                                          // [RULE23]
	assign sclOe_n = ~sclLow_q;                                          // [RULE23]

	// Shifter, bit counter and buffer.
	// Transmit shifts out from the top bit and fills with ones, so the line
	// is released once the byte is through. Receive shifts in at the bottom
	// on each clock fall. A late rewrite restarts the byte from its first bit,
	// which may corrupt the transfer on the line; software sees this through
	// the write collision flag.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shift_q  <= 8'h00;
			bitCnt_q <= 4'h0;
			buf_q    <= 8'h00;
		end else begin
			if (bufTx || bufLate) begin
				buf_q    <= avs_writedata[7:0];                          // [RULE17]
				shift_q  <= avs_writedata[7:0];
				bitCnt_q <= 4'h0;
			end else if (state_q == S_TX_LOW && state_d == S_TX_HIGH) begin
				bitCnt_q <= bitCnt_q + 4'h1;
			end else if (state_q == S_TX_HIGH && state_d == S_TX_LOW) begin
				shift_q  <= {shift_q[6:0], 1'b1};                        // [RULE14]
			end else if (goRecv) begin
				bitCnt_q <= 4'h0;
			end else if (state_q == S_RX_HIGH && state_d == S_RX_LOW) begin
				shift_q  <= {shift_q[6:0], sdaHi};                       // [RULE19]
				bitCnt_q <= bitCnt_q + 4'h1;
			end else if (rxDone) begin
				buf_q    <= shift_q;                                     // [RULE19]
			end
		end
	end

	// Request bits and flags; a hardware set wins over a software clear.
	// A clear that meets a new event in the same cycle would otherwise lose
	// that event without trace, which is worse than a flag left standing.
	// The request bits clear themselves when their condition completes or is
	// aborted by a collision, so software only ever sets them.
	// The rewrite window opens on the first colliding write while a byte is
	// transmitted and closes two clocks later.
	wire swClrFlags = wrFlags;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			startReq_q   <= 1'b0;
			restartReq_q <= 1'b0;
			recvReq_q    <= 1'b0;
			ack_status_q    <= 1'b0;
			write_collision_q       <= 1'b0;
			coll_q       <= 1'b0;
			irq_q        <= 1'b0;
			bufFull_q    <= 1'b0;
			startSeen_q  <= 1'b0;
			ovf_q        <= 1'b0;
			wcolWin_q    <= 2'h0;
			reload_q     <= RELOAD_RST;
		end else begin
			if (wrReload)
				reload_q <= avs_writedata[6:0];                          // [RULE22]
			startReq_q   <= (goStart & ~startColl)
			              | (startReq_q & ~((state_q == S_ST_HOLD) & brgZero) & ~stColl); // [RULE4]
			restartReq_q <= goRestart
			              | (restartReq_q & ~((state_q == S_RS_HOLD) & brgZero) & ~rsColl); // [RULE10]
			recvReq_q    <= goRecv | (recvReq_q & ~rxDone);              // [RULE19]
			if (txAck)
				ack_status_q <= sdaHi;                                      // [RULE15]
			write_collision_q <= (wrBuf & (bufBlock | shifting))                    // [RULE6]
			        | (write_collision_q & ~(swClrFlags & ~avs_writedata[C2_WRITE_COLLISION]));  // [RULE17]
			coll_q <= startColl | stColl | rsColl
			        | (coll_q & ~(swClrFlags & ~avs_writedata[C2_COLL])); // [RULE5]
			irq_q  <= txAck | rxDone
			        | ((state_q == S_ST_HOLD) & brgZero)
			        | ((state_q == S_RS_HOLD) & brgZero)                 // [RULE10]
			        | (irq_q & ~(swClrFlags & ~avs_writedata[C2_IRQ]));  // [RULE16]
			wcolWin_q <= (wrBuf & shifting & (wcolWin_q == 2'h0)) ? WRITE_COLLISION_CYCLES :
			             (wcolWin_q != 2'h0) ? wcolWin_q - 2'h1 : 2'h0;
			bufFull_q <= bufTx | rxDone                                  // [RULE20]
			           | (bufFull_q & ~((state_q == S_TX_HIGH) & brgZero
			                            & (bitCnt_q == BITS_BYTE))      // [RULE12]
			                         & ~rdBuf);                          // [RULE20]
			startSeen_q <= ((state_d == S_ST_HOLD) & (state_q == S_ST_WAIT))  // [RULE3]
			             | ((state_d == S_RS_HOLD) & (state_q == S_RS_HIGH))
			             | (startSeen_q & ~(wrStatus & ~avs_writedata[ST_START]));
			ovf_q <= (rxDone & bufFull_q)                                // [RULE21]
			       | (ovf_q & ~(wrStatus & ~avs_writedata[ST_OVF]));
		end
	end

	// Bus slave: every access answers one cycle after it is taken.
	// Read data is registered at the taking edge and stands until the next
	// read, so it is settled when the master sees waitrequest low.
	// Unmapped offsets read as zero and ignore writes.
	wire [31:0] rdMux =
		(avs_address == OFS_CTRL2)  ? {22'h0, irq_q, coll_q, write_collision_q, ack_status_q,
		                               2'b00, recvReq_q, 1'b0, restartReq_q, startReq_q} :
		(avs_address == OFS_STATUS) ? {25'h0, ovf_q, 2'b00, startSeen_q, 2'b00, bufFull_q} :
		(avs_address == OFS_RELOAD) ? {25'h0, reload_q} :
		(avs_address == OFS_BUF)    ? {24'h0, buf_q} : 32'h0;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q    <= 1'b0;
			rdData_q <= 32'h0;
		end else begin
			ack_q    <= hit;
			if (rdHit)
				rdData_q <= rdMux;
		end
	end
	assign avs_readdata    = rdData_q;
	assign avs_waitrequest = ~ack_q;
endmodule
`default_nettype wire

// ---- hdl/ims_pkg.sv ----
// Constants for the two-wire bus master sequencer: register map, field positions, timing.
// Assumes a 10 MHz system clock and an Avalon-MM slave port with 32-bit data.
// Function
// RULE1: While SCL is released, hold the counter until SCL reads high, then reload.
// RULE2: Setting start_req with both lines high reloads and starts the counter.
// RULE3: Counter expiry with both lines high pulls SDA low and sets start_seen.
// RULE4: After SDA low, one more period, then clear start_req and hold SDA low.
// RULE5: Lines low at start, or SCL low before SDA driven, sets collision and aborts.
// RULE6: Buffer writes during Start, Repeated Start or receive are dropped and flag write_collision.
// RULE7: Writes to the low five request bits are ignored until a Start completes.
// RULE8: restart_req only takes effect when the master logic is idle.
// RULE9: Repeated Start: SCL low, SDA released, SCL released, both high, then SDA low.
// RULE10: Repeated Start ends clearing restart_req, keeping SDA low; irq_flag after expiry.
// RULE11: Repeated Start collision: SDA low as SCL rises, or SCL low before SDA driven.
// RULE12: A buffer write sets buf_full and starts a byte; buf_full clears after eight bits.
// RULE13: Each bit changes after SCL falls; SCL low one period, high one period.
// RULE14: After the eighth falling edge, SDA is released for the slave acknowledge.
// RULE15: At the ninth falling edge, sample acknowledge into ack_status (low means acknowledged).
// RULE16: After the ninth clock set irq_flag, halt, SCL low, SDA unchanged until next write.
// RULE17: Write while shifting sets write_collision; a rewrite within two cycles still updates.
// RULE18: Software sets recv_req only while idle; otherwise the request is ignored.
// RULE19: Receive toggles SCL per rollover, shifts SDA in, then stores, flags and halts.
// RULE20: Receive sets buf_full on buffer load; reading the buffer clears it.
// RULE21: rx_overflow sets when a byte completes while buf_full is still set.
// RULE22: Counter reloads from the low seven reload bits and counts down twice per cycle; the Repeated Start data phase loads only the low six.
// RULE23: SDA and SCL are open drain: pulled low to assert, released to float high.
package ims_pkg;
	localparam logic [3:0] OFS_CTRL2  = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_RELOAD = 4'h8;
	localparam logic [3:0] OFS_BUF    = 4'hC;
	// Second control register fields.
	localparam int         C2_START   = 0;
	localparam int         C2_RESTART = 1;
	localparam int         C2_RECV    = 3;
	localparam int         C2_ACK     = 6;
	localparam int         C2_WRITE_COLLISION    = 7;
	localparam int         C2_COLL    = 8;
	localparam int         C2_IRQ     = 9;
	// Status register fields.
	localparam int         ST_BUFFULL = 0;
	localparam int         ST_START   = 3;
	localparam int         ST_OVF     = 6;
	localparam logic [4:0] REQ_MASK   = 5'h1F;
	localparam logic [6:0] RELOAD_RST = 7'h09;
	// Rewrite grace window after a colliding write, two instruction cycles.
	localparam int         WRITE_COLLISION_TCY     = 2;
	localparam int         CLK_PER_TCY  = 1;
	localparam logic [1:0] WRITE_COLLISION_CYCLES  = 2'(WRITE_COLLISION_TCY * CLK_PER_TCY);
	localparam logic [3:0] BITS_BYTE    = 4'h8;
	localparam logic [3:0] BITS_ACK     = 4'h9;
endpackage

// ---- dv/ims_asserts.sv ----
// Port checker for the two-wire bus master sequencer.
// Assumes it is bound to ims_master_seq and sees only its ports.
`default_nettype none
module ims_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic sdaOut,
	input wire logic sdaOe_n,
	input wire logic sclIn,
	input wire logic sclOut,
	input wire logic sclOe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	chk_ans_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not one cycle after request");
	chk_ans_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	chk_no_answer: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("bus answer without request");
	chk_drive_low: assert property (!sdaOut && !sclOut)
		else $error("line driven high");
	chk_sda_release: assert property ($rose(sdaOe_n) |-> !sclOe_n)
		else $error("data released while clock released");
	chk_scl_high: assert property ($rose(sclOe_n) |=> sclOe_n [*2])
		else $error("clock high time too short");
	chk_scl_stretch: assert property (sclOe_n && !sclIn |=> sclOe_n)
		else $error("clock pulled while held low outside");
	chk_start_hold: assert property ($fell(sdaOe_n) && sclOe_n |=> !sdaOe_n [*2])
		else $error("start data low not held");
endmodule
`default_nettype wire

// ---- dv/ims_slave_model.sv ----
// Open-drain slave: captures bytes, answers acknowledge, sends bytes, stretches the clock.
// Assumes the bench resolves the wired lines and pulses arm before each byte.
`default_nettype none
module ims_slave_model (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       sda,
	input  wire logic       scl,
	input  wire logic       arm,
	input  wire logic       rx,
	input  wire logic       ackEn,
	input  wire logic       stretch,
	input  wire logic [7:0] txByte,
	output logic            sdaPull,
	output logic            sclPull,
	output logic      [7:0] seen
);
	logic [3:0] k;
	logic [2:0] hold;
	logic       sclPrev;
	logic [8:0] pat;
	assign pat     = rx ? {txByte, 1'b1} : {8'hFF, !ackEn};
	assign sclPull = hold != 3'h0;
	// Data is pulled low only after a seen clock fall or on arm while the clock is low, so the model never fakes a start.
	always_ff @(posedge clk_sys) begin
		sclPrev <= scl;
		if (rst) begin
			k <= 4'hF;
			sdaPull <= 1'b0;
			hold <= 3'h0;
			seen <= 8'h00;
		end else if (arm) begin
			k <= 4'h0;
			sdaPull <= !scl && !pat[8];
		end else if (scl && !sclPrev) begin
			k <= (k == 4'hF) ? k : k + 4'h1;
			if (k < 4'h8)
				seen <= {seen[6:0], sda};
		end else if (!scl && sclPrev) begin
			sdaPull <= k < 4'h9 && !pat[4'h8 - k];
			if (stretch)
				hold <= 3'h6;
		end else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the two-wire bus master sequencer.
// Assumes ims_master_seq and a slave model on pulled-up open-drain lines.
`default_nettype none
module tb_top import ims_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys;
	logic        rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, sdaOut, sdaOe_n, sclOut, sclOe_n, sdaPull, sclPull;
	logic        arm = 1'b0, rx = 1'b0, ackEn = 1'b1, stretch = 1'b0;
	logic        pullSda = 1'b0, pullScl = 1'b0;
	logic [7:0]  txByte = 8'h00;
	logic [7:0]  seen;
	logic [31:0] rdv;
	int          n_errors = 0, num_checks = 0, cyc = 0;
	logic [3:0]  rowAddr [5] = '{OFS_CTRL2, OFS_STATUS, OFS_RELOAD, OFS_BUF, 4'h2};
	logic [31:0] rowExp  [5] = '{32'h0, 32'h0, {25'h0, RELOAD_RST}, 32'h0, 32'h0};
	wire sda = !((!sdaOe_n && !sdaOut) || sdaPull || pullSda);
	wire scl = !((!sclOe_n && !sclOut) || sclPull || pullScl);
	ims_master_seq DUT (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sdaIn(sda), .sdaOut, .sdaOe_n,
		.sclIn(scl), .sclOut, .sclOe_n);
	ims_slave_model partner (.clk_sys, .rst, .sda, .scl, .arm, .rx, .ackEn, .stretch,
		.txByte, .sdaPull, .sclPull, .seen);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic busOp(input logic [3:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk_sys);
		{avs_address, avs_write, avs_read, avs_writedata, avs_byteenable} <= {a, w, !w, d, be};
		@(posedge clk_sys);
		while (avs_waitrequest)
			@(posedge clk_sys);
		rdv = avs_readdata;
		{avs_read, avs_write} <= 2'b00;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		busOp(a, 1'b0, 32'h0, 4'h0);
		chk(rdv & m, e);
	endtask
	task automatic waitBit(input logic [3:0] a, input int b, input logic v);
		for (int i = 0; i < 300; i++) begin
			busOp(a, 1'b0, 32'h0, 4'h0);
			if (rdv[b] === v)
				break;
		end
		chk({31'h0, rdv[b]}, {31'h0, v});
	endtask
	// Flags are cleared first, so each byte is judged on its own flags.
	task automatic xfer(input logic r, input logic [7:0] b, input logic a);
		busOp(OFS_CTRL2, 1'b1, 32'h0, 4'h2);
		{arm, rx, txByte, ackEn} <= {1'b1, r, b, a};
		@(posedge clk_sys);
		arm <= 1'b0;
		if (r)
			busOp(OFS_CTRL2, 1'b1, 32'h8, 4'h1);
		else
			busOp(OFS_BUF, 1'b1, {24'h0, b}, 4'h1);
	endtask
	task automatic endTest(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize;
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (rowAddr[i]) begin
			busOp(rowAddr[i], 1'b0, 32'h0, 4'h0);
			chk(rdv, rowExp[i]);
		end
		endTest("reset values");
		busOp(OFS_RELOAD, 1'b1, 32'hB0, 4'hF);
		rc(OFS_RELOAD, 32'hFF, 32'h30);
		{pullSda, pullScl} <= 2'b11;
		busOp(OFS_CTRL2, 1'b1, 32'h1, 4'h1);
		waitBit(OFS_CTRL2, C2_COLL, 1'b1);
		rc(OFS_CTRL2, 32'h1, 32'h0);
		{pullSda, pullScl} <= 2'b00;
		endTest("start collision");
		busOp(OFS_CTRL2, 1'b1, 32'h0, 4'h2);
		busOp(OFS_CTRL2, 1'b1, 32'h1, 4'h1);
		busOp(OFS_BUF, 1'b1, 32'hA5, 4'h1);
		busOp(OFS_CTRL2, 1'b1, 32'h8, 4'h1);
		waitBit(OFS_CTRL2, C2_START, 1'b0);
		rc(OFS_CTRL2, 32'h88, 32'h80);
		rc(OFS_STATUS, 32'h8, 32'h8);
		rc(OFS_BUF, 32'hFF, 32'h0);
		endTest("start");
		stretch <= 1'b1;
		xfer(1'b0, 8'h5A, 1'b1);
		rc(OFS_STATUS, 32'h1, 32'h1);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		rc(OFS_CTRL2, 32'h40, 32'h0);
		rc(OFS_STATUS, 32'h1, 32'h0);
		chk({24'h0, seen}, 32'h5A);
		endTest("transmit with acknowledge");
		stretch <= 1'b0;
		xfer(1'b0, 8'h81, 1'b0);
		repeat (20) @(posedge clk_sys);
		busOp(OFS_BUF, 1'b1, 32'h11, 4'h1);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		rc(OFS_CTRL2, 32'hC0, 32'hC0);
		chk({24'h0, seen}, 32'h81);
		endTest("transmit without acknowledge");
		xfer(1'b1, 8'hC3, 1'b1);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		rc(OFS_CTRL2, 32'h8, 32'h0);
		rc(OFS_STATUS, 32'h1, 32'h1);
		rc(OFS_BUF, 32'hFF, 32'hC3);
		rc(OFS_STATUS, 32'h1, 32'h0);
		xfer(1'b1, 8'h3C, 1'b1);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		xfer(1'b1, 8'h5A, 1'b1);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		rc(OFS_STATUS, 32'h41, 32'h41);
		endTest("receive and overflow");
		busOp(OFS_STATUS, 1'b1, 32'h0, 4'hF);
		busOp(OFS_CTRL2, 1'b1, 32'h0, 4'h2);
		busOp(OFS_CTRL2, 1'b1, 32'h2, 4'h1);
		waitBit(OFS_CTRL2, C2_RESTART, 1'b0);
		waitBit(OFS_CTRL2, C2_IRQ, 1'b1);
		rc(OFS_STATUS, 32'h8, 32'h8);
		endTest("repeated start");
		summarize;
	end
endmodule
bind ims_master_seq ims_asserts chk_u (.clk_sys, .rst, .avs_read, .avs_write,
	.avs_waitrequest, .sdaOut, .sdaOe_n, .sclIn, .sclOut, .sclOe_n);
`default_nettype wire
